// File: pmic_irq_pkg.sv
// Constants shared by the fault interrupt flag logic
package pmic_irq_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] ADDR_ENABLE_ONE = 8'h05;
  localparam logic [7:0] ADDR_ENABLE_TWO = 8'h06;
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h07;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h08;

  // ****************************************
  // Reset values and access masks
  // ****************************************
  localparam logic [7:0] ENABLE_ONE_RESET = 8'h7F;
  localparam logic [7:0] ENABLE_ONE_WMASK = 8'h7C;
  localparam logic [7:0] ENABLE_TWO_RESET = 8'hFF;
  localparam logic [7:0] DATA_ZERO        = 8'h00;

  // ****************************************
  // Status one field positions
  // ****************************************
  localparam int S1_TEMP_CHANGE  = 7;
  localparam int S1_THERMAL_SD   = 6;
  localparam int S1_EARLY_WARN   = 5;
  localparam int S1_THERM_HIGH   = 4;
  localparam int S1_THERM_LOW    = 3;
  localparam int S1_INPUT_UV     = 2;
  localparam int S1_MEASURE_DONE = 1;
  localparam int S1_PROGRAM_DONE = 0;

  // ****************************************
  // Status two field positions
  // ****************************************
  localparam int S2_BOOST_UV     = 7;
  localparam int S2_HIGH_GATE_UV = 6;
  localparam int S2_INVERTER_UV  = 5;
  localparam int S2_POS_SRC_UV   = 4;
  localparam int S2_NEG_GATE_UV  = 3;
  localparam int S2_BIAS_FAULT   = 2;
  localparam int S2_NEG_SRC_UV   = 1;
  localparam int S2_TEMP_DONE    = 0;

  // ****************************************
  // Fault input vector
  // ****************************************
  localparam int FAULT_WIDTH = 12;

  // ****************************************
  // Temperature change detection
  // ****************************************
  localparam int             TEMP_WIDTH     = 8;
  localparam logic [8:0]     TEMP_DELTA_MIN = 9'h003;

endpackage

// File: pmic_input_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous levels
`timescale 1ns/1ps
module pmic_input_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] level_r;

  // ****************************************
  // Per-bit chain
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      // Chain; only stage two and three are compared
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          stage1_r[gi] <= 1'b0;
          stage2_r[gi] <= 1'b0;
          stage3_r[gi] <= 1'b0;
          level_r[gi]  <= 1'b0;
        end else begin
          stage1_r[gi] <= async_i[gi];
          stage2_r[gi] <= stage1_r[gi];
          stage3_r[gi] <= stage2_r[gi];
          if (stage2_r[gi] == stage3_r[gi]) begin
            level_r[gi] <= stage3_r[gi];
          end
        end
      end
    end
  endgenerate

  assign level_o = level_r;

endmodule

// File: pmic_fault_interrupt_flags.sv
// Interrupt enable and status flags of the power chip with its interrupt pin
`timescale 1ns/1ps
module pmic_fault_interrupt_flags
  import pmic_irq_pkg::*;
(
  input  wire logic                  CLOCK_I,
  input  wire logic                  RSTN_I,
  input  wire logic [7:0]            REG_ADDR_I,
  input  wire logic                  REG_WR_I,
  input  wire logic [7:0]            REG_WDATA_I,
  input  wire logic                  REG_RD_I,
  output logic      [7:0]            REG_RDATA_O,
  input  wire logic                  THERMAL_SHUTDOWN_I,
  input  wire logic                  EARLY_WARNING_I,
  input  wire logic                  THERMISTOR_HIGH_I,
  input  wire logic                  THERMISTOR_LOW_I,
  input  wire logic                  INPUT_UNDERVOLTAGE_I,
  input  wire logic                  BOOST_UV_I,
  input  wire logic                  HIGH_GATE_UV_I,
  input  wire logic                  INVERTER_UV_I,
  input  wire logic                  POS_SOURCE_UV_I,
  input  wire logic                  NEG_GATE_UV_I,
  input  wire logic                  BIAS_FAULT_I,
  input  wire logic                  NEG_SOURCE_UV_I,
  input  wire logic                  TEMP_DONE_I,
  input  wire logic [TEMP_WIDTH-1:0] TEMP_VALUE_I,
  input  wire logic                  MEASURE_DONE_I,
  input  wire logic                  PROGRAM_DONE_I,
  output logic                       INTERRUPT_OUT_N_O
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [FAULT_WIDTH-1:0] fault_raw;
  logic [FAULT_WIDTH-1:0] fault_lvl;
  logic                   thermal_shutdown_flag;
  logic                   early_warning_flag;
  logic                   thermistor_high_flag;
  logic                   thermistor_low_flag;
  logic                   input_undervoltage_flag;
  logic                   boost_undervoltage_flag;
  logic                   high_gate_undervoltage_flag;
  logic                   inverter_undervoltage_flag;
  logic                   pos_source_undervoltage_flag;
  logic                   neg_gate_undervoltage_flag;
  logic                   bias_fault_flag;
  logic                   neg_source_undervoltage_flag;
  logic [7:0]             enable_one_r;
  logic [7:0]             enable_two_r;
  logic                   temp_change_flag_r;
  logic                   measure_done_flag_r;
  logic                   program_done_flag_r;
  logic                   temp_conv_done_flag_r;
  logic [TEMP_WIDTH-1:0]  prev_temp_r;
  logic                   have_prev_r;
  logic [8:0]             temp_delta;
  logic                   temp_jump;
  logic [7:0]             status_one;
  logic [7:0]             status_two;
  logic                   rd_status_one;
  logic                   rd_status_two;
  logic [7:0]             rdata_nxt;
  logic [7:0]             rdata_r;
  logic                   int_n_r;
  logic                   int_n_nxt;
  logic [7:0]             req_one;
  logic [7:0]             req_two;

  // Address match for a strobe
  function automatic logic addr_hit(input logic strobe, input logic [7:0] addr,
                                    input logic [7:0] target);
    addr_hit = strobe && (addr == target);
  endfunction

  // ****************************************
  // Fault level synchronisers
  // ****************************************
  // Raw fault pins, thermal shutdown in the top bit
  assign fault_raw = {THERMAL_SHUTDOWN_I, EARLY_WARNING_I, THERMISTOR_HIGH_I,
                      THERMISTOR_LOW_I, INPUT_UNDERVOLTAGE_I, BOOST_UV_I,
                      HIGH_GATE_UV_I, INVERTER_UV_I, POS_SOURCE_UV_I,
                      NEG_GATE_UV_I, BIAS_FAULT_I, NEG_SOURCE_UV_I};

  // Pins are asynchronous; filtered before any flag sees them
  pmic_input_sync #(
    .WIDTH   (FAULT_WIDTH)
  ) u_fault_sync (
    .clk_i   (CLOCK_I),
    .rst_n_i (RSTN_I),
    .async_i (fault_raw),
    .level_o (fault_lvl)
  );

  // ****************************************
  // Named fault levels
  // ****************************************
  // Unpacked in the same order as the raw vector
  assign {thermal_shutdown_flag, early_warning_flag, thermistor_high_flag,
          thermistor_low_flag, input_undervoltage_flag, boost_undervoltage_flag,
          high_gate_undervoltage_flag, inverter_undervoltage_flag,
          pos_source_undervoltage_flag, neg_gate_undervoltage_flag,
          bias_fault_flag, neg_source_undervoltage_flag} = fault_lvl;

  // ****************************************
  // Status vectors
  // ****************************************
  // Status one: events sticky, faults live
  always_comb begin
    status_one                  = DATA_ZERO;
    status_one[S1_TEMP_CHANGE]  = temp_change_flag_r;
    status_one[S1_THERMAL_SD]   = thermal_shutdown_flag;
    status_one[S1_EARLY_WARN]   = early_warning_flag;
    status_one[S1_THERM_HIGH]   = thermistor_high_flag;
    status_one[S1_THERM_LOW]    = thermistor_low_flag;
    status_one[S1_INPUT_UV]     = input_undervoltage_flag;
    status_one[S1_MEASURE_DONE] = measure_done_flag_r;
    status_one[S1_PROGRAM_DONE] = program_done_flag_r;
  end

  // Status two: same bit order as enable two
  always_comb begin
    status_two                  = DATA_ZERO;
    status_two[S2_BOOST_UV]     = boost_undervoltage_flag;
    status_two[S2_HIGH_GATE_UV] = high_gate_undervoltage_flag;
    status_two[S2_INVERTER_UV]  = inverter_undervoltage_flag;
    status_two[S2_POS_SRC_UV]   = pos_source_undervoltage_flag;
    status_two[S2_NEG_GATE_UV]  = neg_gate_undervoltage_flag;
    status_two[S2_BIAS_FAULT]   = bias_fault_flag;
    status_two[S2_NEG_SRC_UV]   = neg_source_undervoltage_flag;
    status_two[S2_TEMP_DONE]    = temp_conv_done_flag_r;
  end

  // ****************************************
  // Read strobe decode
  // ****************************************
  // Reads of the status registers clear their event bits
  assign rd_status_one = addr_hit(REG_RD_I, REG_ADDR_I, ADDR_STATUS_ONE);
  assign rd_status_two = addr_hit(REG_RD_I, REG_ADDR_I, ADDR_STATUS_TWO);

  // ****************************************
  // Enable registers
  // ****************************************
  // Enable one: only the fault enables are writable
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      enable_one_r <= ENABLE_ONE_RESET;
    end else if (addr_hit(REG_WR_I, REG_ADDR_I, ADDR_ENABLE_ONE)) begin
      enable_one_r <= (REG_WDATA_I & ENABLE_ONE_WMASK) |
                      (enable_one_r & ~ENABLE_ONE_WMASK);
    end
  end

  // Enable two: every bit writable
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      enable_two_r <= ENABLE_TWO_RESET;
    end else if (addr_hit(REG_WR_I, REG_ADDR_I, ADDR_ENABLE_TWO)) begin
      enable_two_r <= REG_WDATA_I;
    end
  end

  // ****************************************
  // Temperature change detection
  // ****************************************
  // Magnitude of difference to previous reading
  always_comb begin
    if (TEMP_VALUE_I >= prev_temp_r) begin
      temp_delta = {1'b0, TEMP_VALUE_I} - {1'b0, prev_temp_r};
    end else begin
      temp_delta = {1'b0, prev_temp_r} - {1'b0, TEMP_VALUE_I};
    end
  end

  // Jump needs a previous reading to compare with
  assign temp_jump = TEMP_DONE_I && have_prev_r && (temp_delta >= TEMP_DELTA_MIN);

  // Previous reading kept for the next comparison
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      prev_temp_r <= {TEMP_WIDTH{1'b0}};
      have_prev_r <= 1'b0;
    end else if (TEMP_DONE_I) begin
      prev_temp_r <= TEMP_VALUE_I;
      have_prev_r <= 1'b1;
    end
  end

  // ****************************************
  // Sticky event flags, cleared by read
  // ****************************************
  // Temperature change; set wins over read clear
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      temp_change_flag_r <= 1'b0;
    end else if (temp_jump) begin
      temp_change_flag_r <= 1'b1;
    end else if (rd_status_one) begin
      temp_change_flag_r <= 1'b0;
    end
  end

  // Bias measurement complete
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      measure_done_flag_r <= 1'b0;
    end else if (MEASURE_DONE_I) begin
      measure_done_flag_r <= 1'b1;
    end else if (rd_status_one) begin
      measure_done_flag_r <= 1'b0;
    end
  end

  // Nonvolatile programming complete
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      program_done_flag_r <= 1'b0;
    end else if (PROGRAM_DONE_I) begin
      program_done_flag_r <= 1'b1;
    end else if (rd_status_one) begin
      program_done_flag_r <= 1'b0;
    end
  end

  // Temperature conversion complete
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      temp_conv_done_flag_r <= 1'b0;
    end else if (TEMP_DONE_I) begin
      temp_conv_done_flag_r <= 1'b1;
    end else if (rd_status_two) begin
      temp_conv_done_flag_r <= 1'b0;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  // Read mux; unmapped addresses read zero
  always_comb begin
    case (REG_ADDR_I)
      ADDR_ENABLE_ONE: rdata_nxt = enable_one_r;
      ADDR_ENABLE_TWO: rdata_nxt = enable_two_r;
      ADDR_STATUS_ONE: rdata_nxt = status_one;
      ADDR_STATUS_TWO: rdata_nxt = status_two;
      default:         rdata_nxt = DATA_ZERO;
    endcase
  end

  // Read data captured on the read strobe
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata_r <= DATA_ZERO;
    end else if (REG_RD_I) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Read data holds until the next read
  assign REG_RDATA_O = rdata_r;

  // ****************************************
  // Interrupt pin
  // ****************************************
  // Per-source requests, gated by their enables
  assign req_one = status_one & enable_one_r;
  assign req_two = status_two & enable_two_r;

  // Pin pulled low while any request stands
  assign int_n_nxt = ~(|req_one | |req_two);

  // Registered so the pin never glitches
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      int_n_r <= 1'b1;
    end else begin
      int_n_r <= int_n_nxt;
    end
  end

  // Active-low pin, released high when idle
  assign INTERRUPT_OUT_N_O = int_n_r;

endmodule

// File: pmic_irq_checker.sv
// Port checker of the fault interrupt flag block
`timescale 1ns/1ps
module pmic_irq_checker
  import pmic_irq_pkg::*;
(
  input wire logic       CLOCK_I,
  input wire logic       RSTN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic       REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic       TEMP_DONE_I,
  input wire logic       MEASURE_DONE_I,
  input wire logic       PROGRAM_DONE_I,
  input wire logic       INTERRUPT_OUT_N_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);
  // Event activity and status one reads
  logic ev;
  logic r1;
  assign ev = TEMP_DONE_I | MEASURE_DONE_I | PROGRAM_DONE_I;
  assign r1 = REG_RD_I && REG_ADDR_I == ADDR_STATUS_ONE;
  // Program and measure done pulses pull the pin two edges on
  property p_prog_pin; PROGRAM_DONE_I |-> ##2 !INTERRUPT_OUT_N_O; endproperty
  a_prog_pin: assert property (p_prog_pin) else $error("pin ignored program done");
  property p_meas_pin; MEASURE_DONE_I |-> ##2 !INTERRUPT_OUT_N_O; endproperty
  a_meas_pin: assert property (p_meas_pin) else $error("pin ignored measure done");
  property p_rst; $rose(RSTN_I) |-> INTERRUPT_OUT_N_O; endproperty
  a_rst: assert property (p_rst) else $error("pin low after reset");
  // Read data of fixed places
  property p_en1;
    REG_RD_I && REG_ADDR_I == ADDR_ENABLE_ONE |=> REG_RDATA_O[1:0] == 2'h3;
  endproperty
  a_en1: assert property (p_en1) else $error("fixed enables not one");
  property p_unmap;
    REG_RD_I && (REG_ADDR_I < ADDR_ENABLE_ONE || REG_ADDR_I > ADDR_STATUS_TWO)
    |=> REG_RDATA_O == DATA_ZERO;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold; !REG_RD_I |=> $stable(REG_RDATA_O); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_conv; TEMP_DONE_I ##1 (REG_RD_I && REG_ADDR_I == ADDR_STATUS_TWO) |=> REG_RDATA_O[0];
  endproperty
  a_conv: assert property (p_conv) else $error("conversion done not seen");
  property p_clear; (r1 && !ev) ##1 !ev ##1 (r1 && !ev) |=> (REG_RDATA_O & 8'h83) == DATA_ZERO;
  endproperty
  a_clear: assert property (p_clear) else $error("event bits not cleared");
  // Main scenarios
  c_clear: cover property (r1 ##2 r1);
  c_conv: cover property (TEMP_DONE_I ##1 REG_RD_I);
  c_pin: cover property ($fell(INTERRUPT_OUT_N_O));
  c_collide: cover property (r1 && MEASURE_DONE_I);
endmodule
bind pmic_fault_interrupt_flags pmic_irq_checker u_chk (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .TEMP_DONE_I(TEMP_DONE_I), .MEASURE_DONE_I(MEASURE_DONE_I),
  .PROGRAM_DONE_I(PROGRAM_DONE_I), .INTERRUPT_OUT_N_O(INTERRUPT_OUT_N_O));

// File: pmic_host_model.sv
// Host processor model on the register port
`timescale 1ns/1ps
module pmic_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic            wr_o,
  output logic      [7:0] wdata_o,
  output logic            rd_o
);
  // Idle port at time zero
  initial {addr_o, wr_o, wdata_o, rd_o} = 18'h0_0000;
  // One-cycle strobe, released data inverted so stale data never matches
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk_i);
    {addr_o, wdata_o, wr_o, rd_o} <= {a, d, w, ~w};
    @(posedge clk_i);
    {wdata_o, wr_o, rd_o} <= {~d, 2'h0};
    #1;
    q = rdata_i;
  endtask
endmodule

// File: testbench.sv
// Self-checking bench of the fault interrupt flag block
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        td = 1'b0;
  logic        md = 1'b0;
  logic        pd = 1'b0;
  logic [11:0] flt = 12'h000;
  logic [7:0]  tv = 8'h00;
  logic [7:0]  adr, wd, rdat, q;
  logic        wr, rd, irq_n;
  int          en1 = 8'h7F, en2 = 8'hFF, s1e = 0, s2e = 0, prev = -1, cyc = 0, b;
  int          errors = 0, tests_run = 0;
  int          al[7] = '{5, 6, 7, 8, 4, 9, 255};
  int          tl[6] = '{52, 55, 52, 49, 0, 255};
  // Design and host
  pmic_fault_interrupt_flags DUT (.CLOCK_I(clk), .RSTN_I(rst_n), .REG_ADDR_I(adr),
    .REG_WR_I(wr), .REG_WDATA_I(wd), .REG_RD_I(rd), .REG_RDATA_O(rdat),
    .THERMAL_SHUTDOWN_I(flt[0]), .EARLY_WARNING_I(flt[1]), .THERMISTOR_HIGH_I(flt[2]),
    .THERMISTOR_LOW_I(flt[3]), .INPUT_UNDERVOLTAGE_I(flt[4]), .BOOST_UV_I(flt[5]),
    .HIGH_GATE_UV_I(flt[6]), .INVERTER_UV_I(flt[7]), .POS_SOURCE_UV_I(flt[8]),
    .NEG_GATE_UV_I(flt[9]), .BIAS_FAULT_I(flt[10]), .NEG_SOURCE_UV_I(flt[11]),
    .TEMP_DONE_I(td), .TEMP_VALUE_I(tv), .MEASURE_DONE_I(md), .PROGRAM_DONE_I(pd),
    .INTERRUPT_OUT_N_O(irq_n));
  pmic_host_model HOST (.clk_i(clk), .rdata_i(rdat), .addr_o(adr), .wr_o(wr),
    .wdata_o(wd), .rd_o(rd));
  // Clock and hang guard
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      print_verdict();
    end
  end
  // Compare and verdict
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Model status from live faults and sticky events
  function automatic int stat(input int a);
    int v;
    v = (a == 7) ? s1e : s2e;
    for (int i = 0; i < 12; i++)
      if (flt[i] && (i < 5) == (a == 7)) v |= 1 << (i < 5 ? 6 - i : 12 - i);
    return v;
  endfunction
  task automatic expect_rd(input int a, input logic [7:0] g);
    int e;
    e = (a == 5) ? en1 : (a == 6) ? en2 : (a == 7 || a == 8) ? stat(a) : 0;
    if (a == 7) s1e = 0;
    if (a == 8) s2e = 0;
    chk(g, 8'(e));
  endtask
  // Register and pin access
  task automatic rchk(input int a);
    HOST.acc(1'b0, 8'(a), 8'h00, q);
    expect_rd(a, q);
  endtask
  task automatic wrt(input int a, input int d);
    HOST.acc(1'b1, 8'(a), 8'(d), q);
    if (a == 5) en1 = d & 8'h7C | 8'h03;
    if (a == 6) en2 = d & 8'hFF;
  endtask
  task automatic pchk();
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, irq_n}, {7'h00, ((stat(7) & en1) | (stat(8) & en2)) == 0});
  endtask
  // Event pulse with a status read on the following cycle
  task automatic pls(input int k, input int v, input int a);
    logic [7:0] r;
    fork
      begin
        @(posedge clk);
        {td, md, pd} <= 3'h4 >> k;
        tv <= 8'(v);
        @(posedge clk);
        {td, md, pd} <= 3'h0;
      end
      begin
        @(posedge clk);
        HOST.acc(1'b0, 8'(a), 8'h00, r);
      end
    join
    if (k == 0 && prev >= 0 && (v - prev >= 3 || prev - v >= 3)) s1e |= 128;
    if (k == 0) prev = v;
    s2e |= (k == 0);
    s1e |= (k == 1) ? 2 : (k == 2);
    expect_rd(a, r);
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'hd2a7));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (al[i]) rchk(al[i]);
    pchk();
    wrt(5, 0);
    wrt(7, 255);
    wrt(8, 255);
    wrt(6, 8'h5A);
    foreach (al[i]) rchk(al[i]);
    wrt(5, 255);
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      @(posedge clk) flt <= 12'h001 << i;
      repeat (6) @(posedge clk);
      rchk(i < 5 ? 7 : 8);
      pchk();
      b = 1 << (i < 5 ? 6 - i : 12 - i);
      wrt(i < 5 ? 5 : 6, 8'hFF ^ b);
      pchk();
      wrt(i < 5 ? 5 : 6, 8'hFF);
    end
    for (int k = 0; k < 16; k++) begin
      wrt(6, $urandom);
      @(posedge clk) flt <= 12'($urandom);
      repeat (6) @(posedge clk);
      rchk(k[0] ? 7 : 8);
      pchk();
    end
    @(posedge clk) flt <= 12'h000;
    repeat (6) @(posedge clk);
    $display("test faults done");
    pls(0, 50, 8);
    foreach (tl[i]) pls(0, tl[i], 7);
    for (int k = 0; k < 6; k++) pls(0, $urandom % 256, 7);
    rchk(8);
    pls(1, 0, 7);
    rchk(7);
    wrt(5, 0);
    pls(2, 0, 8);
    pchk();
    rchk(7);
    pchk();
    // Event and read clear in one cycle: the set wins
    fork
      begin
        @(posedge clk) md <= 1'b1;
        @(posedge clk) md <= 1'b0;
      end
      HOST.acc(1'b0, 8'h07, 8'h00, q);
    join
    expect_rd(7, q);
    s1e |= 2;
    rchk(7);
    pchk();
    $display("test events done");
    print_verdict();
  end
endmodule
